/* adsc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module adsc_regs
    import adsc_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // register port from the serial engine
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    // analog and detector inputs (asynchronous)
    input  wire logic              adc_done,
    input  wire logic [4:0]        adc_code,
    input  wire logic              bus_supply_present,
    input  wire logic              data_lines_shorted,
    input  wire logic              charger_attached,
    input  wire logic              power_switch_on,
    input  wire logic              power_save_cond,
    input  wire logic              device_active,
    // outputs to the chip
    output logic                   charge_current_set_drive,
    output logic                   soft_reset_pulse,
    output logic                   power_save_state,
    output logic                   ident_start,
    output adsc_pkg::adsc_class_e  id_class,
    output logic [3:0]             key_index,
    output logic                   class_variant
);
    import adsc_pkg::*;

    localparam int NSYNC = 10;
    // stages start at the filtered reset word, so no false change follows
    localparam logic [NSYNC-1:0] SYNC_RST = {1'b0, RST_ADC, 4'h0};

    // three-stage synchronisers for asynchronous inputs
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    logic [NSYNC-1:0] s_in;
    logic [NSYNC-1:0] filt_r;
    logic [NSYNC-1:0] filt_nxt;
    assign s_in = {adc_done, adc_code, bus_supply_present,
                   data_lines_shorted, charger_attached, power_switch_on};
    // power save condition and activity level synchronisers
    logic             ps_s1_r;
    logic             ps_s2_r;
    logic             ps_s3_r;
    logic             ps_f_r;
    logic             ps_f_nxt;
    logic             ac_s1_r;
    logic             ac_s2_r;
    logic             ac_s3_r;
    logic             ac_f_r;
    logic             ac_f_nxt;

    // accept a change once stages two and three agree
    always_comb begin
        for (int i = 0; i < NSYNC; i++) begin
            filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
        end
        ps_f_nxt = (ps_s2_r == ps_s3_r) ? ps_s3_r : ps_f_r;
        ac_f_nxt = (ac_s2_r == ac_s3_r) ? ac_s3_r : ac_f_r;
    end

    // synchroniser flops; adc code filtered field resets to open code
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s1_r    <= SYNC_RST;
            s2_r    <= SYNC_RST;
            s3_r    <= SYNC_RST;
            filt_r  <= SYNC_RST;
            ps_s1_r <= 1'b0;
            ps_s2_r <= 1'b0;
            ps_s3_r <= 1'b0;
            ps_f_r  <= 1'b0;
            ac_s1_r <= 1'b0;
            ac_s2_r <= 1'b0;
            ac_s3_r <= 1'b0;
            ac_f_r  <= 1'b0;
        end else begin
            s1_r    <= s_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            filt_r  <= filt_nxt;
            ps_s1_r <= power_save_cond;
            ps_s2_r <= ps_s1_r;
            ps_s3_r <= ps_s2_r;
            ps_f_r  <= ps_f_nxt;
            ac_s1_r <= device_active;
            ac_s2_r <= ac_s1_r;
            ac_s3_r <= ac_s2_r;
            ac_f_r  <= ac_f_nxt;
        end
    end

    // filtered fields of the synchronised word
    logic       f_adc_done, f_bus, f_short, f_chg, f_fet;
    logic [4:0] f_code;
    assign f_adc_done = filt_r[9];
    assign f_code     = filt_r[8:4];
    assign f_bus      = filt_r[3];
    assign f_short    = filt_r[2];
    assign f_chg      = filt_r[1];
    assign f_fet      = filt_r[0];

    // code classification
    adsc_id_decode u_decode (
        .id_code       (f_code),
        .id_class      (id_class),
        .key_index     (key_index),
        .class_variant (class_variant)
    );

    // status word assembled from live detector state
    logic [7:0] status_w;
    assign status_w = {1'b0,
                       f_fet,
                       f_chg,
                       f_short,
                       (f_code == CODE_LOW),
                       (f_code == CODE_OPEN),
                       f_bus,
                       f_adc_done};

    // writable registers
    logic [7:0] ctrl2_r, ctrl2_nxt;
    logic [7:0] control_r, control_nxt;
    logic [7:0] delay_r, delay_nxt;
    logic [7:0] mode_r, mode_nxt;
    logic       soft_pend_r, soft_pend_nxt;
    logic       wr_ctrl2;
    logic       wr_control;
    logic       wr_delay;
    logic       wr_mode;
    logic       rd_mode;

    // per-register write strobes and the mode register read strobe
    assign wr_ctrl2   = reg_wr && (reg_addr == ADDR_CTRL2);
    assign wr_control = reg_wr && (reg_addr == ADDR_CONTROL);
    assign wr_delay   = reg_wr && (reg_addr == ADDR_DELAY);
    assign wr_mode    = reg_wr && (reg_addr == ADDR_MODE);
    assign rd_mode    = reg_rd && (reg_addr == ADDR_MODE);

    // next values of the register bank, soft reset included
    always_comb begin
        ctrl2_nxt     = ctrl2_r;
        control_nxt   = control_r;
        delay_nxt     = delay_r;
        mode_nxt      = mode_r;
        soft_pend_nxt = 1'b0;
        if (soft_pend_r) begin
            // soft reset completes: defaults back, flag set
            ctrl2_nxt   = RST_CTRL2;
            control_nxt = RST_CONTROL;
            delay_nxt   = RST_DELAY;
            mode_nxt    = RST_MODE;
        end else begin
            if (wr_ctrl2) begin
                ctrl2_nxt = reg_wdata;
            end
            if (wr_control) begin
                control_nxt = reg_wdata;
                control_nxt[BIT_SOFT_RST] = 1'b0;
                soft_pend_nxt = reg_wdata[BIT_SOFT_RST];
            end
            if (wr_delay) begin
                delay_nxt = reg_wdata;
            end
            if (rd_mode) begin
                mode_nxt[BIT_RST_FLAG] = 1'b0;
            end
            if (wr_mode) begin
                mode_nxt[7:1] = {5'h00, reg_wdata[BIT_POWER_SAVE_STATE], 1'b0};
            end
            mode_nxt[BIT_ACTIVE] = ac_f_r;
            if (control_r[BIT_AUTO_PS]) begin
                mode_nxt[BIT_POWER_SAVE_STATE] = ps_f_r;
            end else if (!wr_mode) begin
                mode_nxt[BIT_POWER_SAVE_STATE] = mode_r[BIT_POWER_SAVE_STATE];
            end
        end
    end

    // register bank flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl2_r     <= RST_CTRL2;
            control_r   <= RST_CONTROL;
            delay_r     <= RST_DELAY;
            mode_r      <= RST_MODE;
            soft_pend_r <= 1'b0;
        end else begin
            ctrl2_r     <= ctrl2_nxt;
            control_r   <= control_nxt;
            delay_r     <= delay_nxt;
            mode_r      <= mode_nxt;
            soft_pend_r <= soft_pend_nxt;
        end
    end

    // chip-facing levels straight from register bits
    assign charge_current_set_drive = ctrl2_r[BIT_CHG_DRIVE];
    assign soft_reset_pulse         = soft_pend_r;
    assign power_save_state         = mode_r[BIT_POWER_SAVE_STATE];

    // delay timer before powered accessory identification
    adsc_dly_e   dly_r, dly_nxt;
    logic [31:0] cyc_r, cyc_nxt;
    logic [4:0]  steps_r, steps_nxt;
    logic        start_r, start_nxt;

    always_comb begin
        dly_nxt   = dly_r;
        cyc_nxt   = cyc_r;
        steps_nxt = steps_r;
        start_nxt = 1'b0;
        case (dly_r)
            DLY_IDLE: begin
                cyc_nxt   = 32'h0000_0000;
                steps_nxt = 5'(delay_r[3:0]) + 5'h01;
                if (f_bus) begin
                    dly_nxt = DLY_WAIT;
                end
            end
            DLY_WAIT: begin
                if (!f_bus) begin
                    dly_nxt = DLY_IDLE;
                end else if (cyc_r == 32'(STEP_CYCLES - 1)) begin
                    cyc_nxt   = 32'h0000_0000;
                    steps_nxt = steps_r - 5'h01;
                    if (steps_r == 5'h01) begin
                        start_nxt = 1'b1;
                        dly_nxt   = DLY_DONE;
                    end
                end else begin
                    cyc_nxt = cyc_r + 32'h0000_0001;
                end
            end
            DLY_DONE: begin
                if (!f_bus) begin
                    dly_nxt = DLY_IDLE;
                end
            end
            default: dly_nxt = DLY_IDLE;
        endcase
        if (soft_pend_r) begin
            dly_nxt = DLY_IDLE;
        end
    end

    // delay timer flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dly_r   <= DLY_IDLE;
            cyc_r   <= 32'h0000_0000;
            steps_r <= 5'h00;
            start_r <= 1'b0;
        end else begin
            dly_r   <= dly_nxt;
            cyc_r   <= cyc_nxt;
            steps_r <= steps_nxt;
            start_r <= start_nxt;
        end
    end

    // one-cycle start pulse for powered identification
    assign ident_start = start_r;

    // read data mux; unmapped addresses read zero
    logic [7:0] rdata_nxt, rdata_r;
    always_comb begin
        case (reg_addr)
            ADDR_ADC_RESULT: rdata_nxt = {3'b000, f_code};
            ADDR_CTRL2:      rdata_nxt = ctrl2_r;
            ADDR_STATUS:     rdata_nxt = status_w;
            ADDR_CONTROL:    rdata_nxt = control_r;
            ADDR_DELAY:      rdata_nxt = delay_r;
            ADDR_MODE:       rdata_nxt = mode_r;
            default:         rdata_nxt = 8'h00;
        endcase
        if (!reg_rd) begin
            rdata_nxt = rdata_r;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // registered read data to the serial engine
    assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

/* adsc_pkg.sv */
`default_nettype none
package adsc_pkg;
    localparam logic [7:0] ADDR_ADC_RESULT = 8'h87;
    localparam logic [7:0] ADDR_CTRL2      = 8'h94;
    localparam logic [7:0] ADDR_STATUS     = 8'hA0;
    localparam logic [7:0] ADDR_CONTROL    = 8'hA1;
    localparam logic [7:0] ADDR_DELAY      = 8'hA2;
    localparam logic [7:0] ADDR_MODE       = 8'hA3;

    localparam logic [7:0] RST_CTRL2   = 8'h04;
    localparam logic [7:0] RST_CONTROL = 8'h60;
    localparam logic [7:0] RST_DELAY   = 8'h94;
    localparam logic [7:0] RST_MODE    = 8'h01;
    localparam logic [4:0] RST_ADC     = 5'h1F;

    localparam int BIT_CHG_DRIVE = 4;
    localparam int BIT_SOFT_RST  = 2;
    localparam int BIT_AUTO_PS   = 5;
    localparam int BIT_RST_FLAG  = 0;
    localparam int BIT_ACTIVE    = 1;
    localparam int BIT_POWER_SAVE_STATE     = 2;

    localparam logic [4:0] CODE_LOW     = 5'h00;
    localparam logic [4:0] CODE_KEY_LO  = 5'h01;
    localparam logic [4:0] CODE_KEY_HI  = 5'h0D;
    localparam logic [4:0] CODE_UART1   = 5'h0E;
    localparam logic [4:0] CODE_UART2   = 5'h0F;
    localparam logic [4:0] CODE_USB1    = 5'h10;
    localparam logic [4:0] CODE_USB2    = 5'h11;
    localparam logic [4:0] CODE_CARKIT1 = 5'h17;
    localparam logic [4:0] CODE_CARKIT2 = 5'h1B;
    localparam logic [4:0] CODE_RC1     = 5'h1D;
    localparam logic [4:0] CODE_RC2     = 5'h1E;
    localparam logic [4:0] CODE_OPEN    = 5'h1F;

    localparam int CLK_MHZ   = 250;
    localparam int DELAY_STEP_MS = 100;
    localparam int STEP_CYCLES_DEF = DELAY_STEP_MS * 1000 * CLK_MHZ;

    typedef enum logic [3:0] {
        ACC_RESERVED = 4'h0,
        ACC_KEY      = 4'h1,
        ACC_UART     = 4'h2,
        ACC_USB      = 4'h3,
        ACC_CARKIT   = 4'h4,
        ACC_REMOTE   = 4'h5,
        ACC_OPEN     = 4'h6
    } adsc_class_e;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_WAIT = 2'b01,
        DLY_DONE = 2'b10
    } adsc_dly_e;
endpackage
`default_nettype wire

/* adsc_id_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module adsc_id_decode
    import adsc_pkg::*;
(
    // code in
    input  wire logic [4:0]  id_code,
    // class out
    output adsc_pkg::adsc_class_e id_class,
    output logic [3:0]       key_index,
    output logic             class_variant
);
    import adsc_pkg::*;

    // map resistance code to accessory class
    always_comb begin
        id_class      = ACC_RESERVED;
        key_index     = 4'h0;
        class_variant = 1'b0;
        if (id_code == CODE_OPEN) begin
            id_class = ACC_OPEN;
        end else if (id_code >= CODE_KEY_LO && id_code <= CODE_KEY_HI) begin
            id_class  = ACC_KEY;
            key_index = 4'(id_code - CODE_KEY_LO);
        end else begin
            case (id_code)
                CODE_UART1:   id_class = ACC_UART;
                CODE_UART2: begin
                    id_class      = ACC_UART;
                    class_variant = 1'b1;
                end
                CODE_USB1:    id_class = ACC_USB;
                CODE_USB2: begin
                    id_class      = ACC_USB;
                    class_variant = 1'b1;
                end
                CODE_CARKIT1: id_class = ACC_CARKIT;
                CODE_CARKIT2: begin
                    id_class      = ACC_CARKIT;
                    class_variant = 1'b1;
                end
                CODE_RC1:     id_class = ACC_REMOTE;
                CODE_RC2: begin
                    id_class      = ACC_REMOTE;
                    class_variant = 1'b1;
                end
                default:      id_class = ACC_RESERVED;
            endcase
        end
    end
endmodule
`default_nettype wire

/* adsc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adsc_host_model (
    // clock
    input  wire logic       clock,
    // register port toward the device
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // one write, held until the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clock);
        #1;
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    // one read, data taken once the answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask
    // keeps untouched fields as they read back
    task automatic rmw(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] v);
        logic [7:0] cur;
        rd(a, cur);
        wr(a, (cur & ~m) | (v & m));
    endtask
endmodule
`default_nettype wire

/* adsc_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adsc_regs_asserts
    import adsc_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // chip outputs
    input wire logic       charge_current_set_drive,
    input wire logic       soft_reset_pulse,
    input wire logic       ident_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic wr_ok;
    // writes in the soft reset cycle are dropped
    assign wr_ok = reg_wr && !soft_reset_pulse;
    a_drive_write: assert property (
        wr_ok && reg_addr == ADDR_CTRL2
        |=> charge_current_set_drive == $past(reg_wdata[4]))
        else $error("drive level not taken from write");
    a_soft_start: assert property (
        wr_ok && reg_addr == ADDR_CONTROL && reg_wdata[2]
        |=> soft_reset_pulse) else $error("soft reset not started");
    a_soft_once: assert property (
        soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    a_soft_restore: assert property (
        soft_reset_pulse |=> !charge_current_set_drive)
        else $error("drive not restored by soft reset");
    a_status_top: assert property (
        reg_rd && reg_addr == ADDR_STATUS |=> !reg_rdata[7])
        else $error("status top bit set");
    a_adc_upper: assert property (
        reg_rd && reg_addr == ADDR_ADC_RESULT |=> reg_rdata[7:5] == 3'h0)
        else $error("adc upper bits set");
    a_ctrl_bit_low: assert property (
        reg_rd && reg_addr == ADDR_CONTROL |=> !reg_rdata[2])
        else $error("soft reset bit reads one");
    a_mode_upper: assert property (
        reg_rd && reg_addr == ADDR_MODE |=> reg_rdata[7:3] == 5'h00)
        else $error("mode upper bits set");
    a_rdata_hold: assert property (
        !reg_rd && !soft_reset_pulse |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_ident_once: assert property (
        ident_start |=> !ident_start) else $error("ident pulse too long");
    // main scenarios
    c_soft: cover property (soft_reset_pulse);
    c_ident: cover property (ident_start);
    c_mode_rd: cover property (reg_rd && reg_addr == ADDR_MODE);
endmodule
bind adsc_regs adsc_regs_asserts u_chk (.clock, .resetn, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .charge_current_set_drive,
    .soft_reset_pulse, .ident_start);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adsc_pkg::*;
    localparam int STEP = 10;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, done, bus, shrt, chg, fet, psc, act;
    logic [4:0] code = 5'h1F;
    logic drive, srp, pss, ids, var_o;
    adsc_class_e cls_o;
    logic [3:0] key_o;
    logic [31:0] rnd = 32'hC090;
    int err_total = 0;
    int n_compared = 0;
    int cnt, exp;
    logic [7:0] ra [7] = '{8'h87, 8'h94, 8'hA1, 8'hA2, 8'hA3, 8'hA3, 8'h55};
    logic [7:0] re [7] = '{8'h1F, 8'h04, 8'h60, 8'h94, 8'h01, 8'h00, 8'h00};
    adsc_regs #(.STEP_CYCLES(STEP)) u_adsc_regs (.clock, .resetn, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .adc_done(done),
        .adc_code(code), .bus_supply_present(bus), .data_lines_shorted(shrt),
        .charger_attached(chg), .power_switch_on(fet), .power_save_cond(psc),
        .device_active(act), .charge_current_set_drive(drive),
        .soft_reset_pulse(srp), .power_save_state(pss), .ident_start(ids),
        .id_class(cls_o), .key_index(key_o), .class_variant(var_o));
    adsc_host_model u_adsc_host_model (.clock, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rdata);
    // clock
    initial begin
        forever #2 clock = ~clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic adsc_class_e cls(input logic [4:0] c);
        if (c inside {[CODE_KEY_LO:CODE_KEY_HI]}) return ACC_KEY;
        if (c inside {CODE_UART1, CODE_UART2}) return ACC_UART;
        if (c inside {CODE_USB1, CODE_USB2}) return ACC_USB;
        if (c inside {CODE_CARKIT1, CODE_CARKIT2}) return ACC_CARKIT;
        if (c inside {CODE_RC1, CODE_RC2}) return ACC_REMOTE;
        if (c == CODE_OPEN) return ACC_OPEN;
        return ACC_RESERVED;
    endfunction
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        {done, bus, shrt, chg, fet, psc, act} = 7'h00;
        settle(6);
        resetn = 1'b1;
        for (int i = 0; i < 7; i++) begin
            u_adsc_host_model.rd(ra[i], d);
            check(d, re[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {done, bus, shrt, chg, fet} = rnd[4:0];
            code = (i < 2) ? {5{i[0]}} : rnd[9:5];
            settle(8);
            u_adsc_host_model.rd(ADDR_STATUS, d);
            check(d, {1'b0, fet, chg, shrt, code == CODE_LOW,
                      code == CODE_OPEN, bus, done});
        end
        $display("test status done");
        for (int c = 0; c < 32; c++) begin
            code = c[4:0];
            settle(8);
            check(cls_o, cls(code));
            if (code inside {[CODE_KEY_LO:CODE_KEY_HI]})
                check(key_o, code - CODE_KEY_LO);
            if (code inside {[CODE_UART1:CODE_USB2], CODE_CARKIT1,
                CODE_CARKIT2, CODE_RC1, CODE_RC2})
                check(var_o, code inside {CODE_UART2, CODE_USB2,
                      CODE_CARKIT2, CODE_RC2});
            u_adsc_host_model.rd(ADDR_ADC_RESULT, d);
            check(d, {3'h0, code});
        end
        $display("test id codes done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            u_adsc_host_model.rmw(ADDR_CTRL2, 8'h10, rnd[7:0]);
            u_adsc_host_model.rd(ADDR_CTRL2, d);
            check(d, RST_CTRL2 | {3'h0, rnd[4], 4'h0});
            check(drive, rnd[4]);
        end
        $display("test drive done");
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            exp = (i == 0) ? 15 : rnd[3:0];
            bus = 1'b0;
            u_adsc_host_model.rmw(ADDR_DELAY, 8'h0F, exp[7:0]);
            settle(10);
            bus = 1'b1;
            cnt = 0;
            while (ids !== 1'b1 && cnt < 300) begin
                settle(1);
                cnt++;
            end
            exp = (exp + 1) * STEP;
            check(cnt >= exp && cnt <= exp + 8, 1);
        end
        $display("test delay done");
        psc = 1'b1;
        act = 1'b1;
        settle(8);
        check(pss, 1);
        u_adsc_host_model.rd(ADDR_MODE, d);
        check(d[2:1], 2'h3);
        psc = 1'b0;
        settle(8);
        check(pss, 0);
        u_adsc_host_model.rmw(ADDR_CONTROL, 8'h20, 8'h00);
        psc = 1'b1;
        settle(8);
        check(pss, 0);
        u_adsc_host_model.wr(ADDR_MODE, 8'h04);
        settle(1);
        check(pss, 1);
        $display("test power save done");
        psc = 1'b0;
        u_adsc_host_model.rmw(ADDR_CTRL2, 8'h10, 8'h10);
        u_adsc_host_model.wr(ADDR_DELAY, 8'h91);
        u_adsc_host_model.wr(ADDR_CONTROL, 8'h44);
        settle(3);
        check(drive, 0);
        u_adsc_host_model.rd(ADDR_DELAY, d);
        check(d, RST_DELAY);
        u_adsc_host_model.rd(ADDR_CONTROL, d);
        check(d, RST_CONTROL);
        u_adsc_host_model.rd(ADDR_MODE, d);
        check(d[0], 1);
        u_adsc_host_model.rd(ADDR_MODE, d);
        check(d[0], 0);
        $display("test soft reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
